// file: hw/sbrwd_defines.vh
// register offsets, field positions, reset values and timing for the staged watchdog
// assumes inclusion by bare name from the watchdog design files
`ifndef SBRWD_DEFINES_VH
`define SBRWD_DEFINES_VH

// register byte offsets
`define SBRWD_A_CTRL 8'h00
`define SBRWD_A_STAGE 8'h04
`define SBRWD_A_CMD 8'h08
`define SBRWD_A_STAT 8'h0C
`define SBRWD_A_MASK 8'h10
`define SBRWD_A_STATE 8'h14

// control register fields
`define SBRWD_C_POST 2:0
`define SBRWD_C_STOP_UI 3
`define SBRWD_C_STOP_PW 4
`define SBRWD_C_MODE 6:5
`define SBRWD_C_DELAY 9:7
`define SBRWD_C_RESTART 10
`define SBRWD_CTRL_RST 11'h018

// stage register fields
`define SBRWD_S_EV1 1:0
`define SBRWD_S_EV2 3:2
`define SBRWD_S_EV3 5:4
`define SBRWD_S_TO1 9:6
`define SBRWD_S_TO2 13:10
`define SBRWD_S_TO3 17:14
`define SBRWD_STAGE_RST 18'h11101

// command bits
`define SBRWD_CMD_TRIG 0
`define SBRWD_CMD_ARM 1

// status bits
`define SBRWD_ST_POST 0
`define SBRWD_ST_ACPI 1
`define SBRWD_ST_RST 2
`define SBRWD_ST_PWR 3
`define SBRWD_ST_OFF 4
`define SBRWD_ST_W 5

// runtime modes
`define SBRWD_M_OFF 2'h0
`define SBRWD_M_ONCE 2'h1
`define SBRWD_M_SINGLE 2'h2
`define SBRWD_M_REPEAT 2'h3

// stage event codes
`define SBRWD_EV_NONE 2'h0
`define SBRWD_EV_ACPI 2'h1
`define SBRWD_EV_RST 2'h2
`define SBRWD_EV_PWR 2'h3

// timing: one second tick
`define SBRWD_TICK_NS 1000000000
`define SBRWD_CLK_NS 8

// selectable times in seconds
`define SBRWD_T_1S 12'h001
`define SBRWD_T_2S 12'h002
`define SBRWD_T_5S 12'h005
`define SBRWD_T_10S 12'h00A
`define SBRWD_T_30S 12'h01E
`define SBRWD_T_1M 12'h03C
`define SBRWD_T_2M 12'h078
`define SBRWD_T_5M 12'h12C
`define SBRWD_T_10M 12'h258
`define SBRWD_T_30M 12'h708

`endif

// file: hw/sbrwd_tick.v
// free running one second tick generator
// assumes a synchronous active high reset
`timescale 1ns/1ps
module sbrwd_tick #(
   parameter TICK_CYCLES = 125000000
) (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   // tick output
   output reg tick_o
);
   reg [26:0] cnt_q;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_q <= 27'h0000000;
         tick_o <= 1'b0;
      end else if (cnt_q == TICK_CYCLES[26:0] - 27'h0000001) begin
         cnt_q <= 27'h0000000;
         tick_o <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 27'h0000001;
         tick_o <= 1'b0;
      end
   end
endmodule // sbrwd_tick

// file: hw/sbrwd_timer.v
// seconds down counter with load, run gate and expiry pulse
// assumes a one second tick pulse from the tick generator
`timescale 1ns/1ps
module sbrwd_timer (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   // control
   input wire load_i,
   input wire [11:0] secs_i,
   input wire clear_i,
   input wire run_i,
   input wire tick_i,
   // status
   output wire [11:0] count_o,
   output reg expired_o
);
   reg [11:0] cnt_q;

   assign count_o = cnt_q;

   always @(posedge clk_sys_i) begin
      if (rst_i || clear_i) begin
         cnt_q <= 12'h000;
         expired_o <= 1'b0;
      end else if (load_i) begin
         cnt_q <= secs_i;
         expired_o <= 1'b0;
      end else if (run_i && tick_i && cnt_q != 12'h000) begin
         cnt_q <= cnt_q - 12'h001;
         expired_o <= (cnt_q == 12'h001);
      end else begin
         expired_o <= 1'b0;
      end
   end
endmodule // sbrwd_timer

// file: hw/sbrwd_top.v
// staged boot and runtime watchdog: register port, boot watchdog, runtime stages, events
// assumes a 125 MHz clock, synchronous reset driven by system reset, boot phase inputs from firmware
//
// Operation
// RULE_01: boot timeout off, 30s up to 30min
// RULE_02: boot timer counts in POST, resets
// RULE_03: interaction option halts at popup or password
// RULE_04: password option halts at password prompt
// RULE_05: one-time mode disables on first trigger
// RULE_06: single mode runs each stage once
// RULE_07: repeated mode reruns last stage forever
// RULE_08: firmware arms runtime watchdog before OS
// RULE_09: selectable start delay before runtime activation
// RULE_10: stage one event always issued, never disabled
// RULE_11: stage two event selectable, disabled default
// RULE_12: stage three event selectable, disabled default
// RULE_13: stage timeouts 1s to 10min, 30s default
// RULE_14: shutdown action gives over-temperature notification
// RULE_15: restart action gives fatal error report
// RULE_16: stages run in order, trigger restarts
// RULE_17: reset returns idle, timers cleared
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "sbrwd_defines.vh"
module sbrwd_top #(
   parameter TICK_CYCLES = `SBRWD_TICK_NS / `SBRWD_CLK_NS
) (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   // register port
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_we_i,
   input wire reg_re_i,
   output reg [31:0] reg_rdata_o,
   // boot phase indications
   input wire post_active_i,
   input wire boot_popup_i,
   input wire setup_pwd_wait_i,
   input wire pwd_entry_i,
   // event outputs
   output reg sys_reset_o,
   output reg pwr_button_o,
   output reg acpi_overtemp_o,
   output reg acpi_fatal_o,
   output wire irq_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_DELAY = 2'h1;
   localparam ST_STAGE = 2'h2;
   localparam ST_DONE = 2'h3;

   // boot timeout selection to seconds
   function [11:0] post_secs;
      input [2:0] sel;
      begin
         case (sel)
            3'h1: post_secs = `SBRWD_T_30S;
            3'h2: post_secs = `SBRWD_T_1M;
            3'h3: post_secs = `SBRWD_T_2M;
            3'h4: post_secs = `SBRWD_T_5M;
            3'h5: post_secs = `SBRWD_T_10M;
            3'h6: post_secs = `SBRWD_T_30M;
            default: post_secs = 12'h000;
         endcase
      end
   endfunction

   // start delay selection to seconds
   function [11:0] delay_secs;
      input [2:0] sel;
      begin
         case (sel)
            3'h1: delay_secs = `SBRWD_T_10S;
            3'h2: delay_secs = `SBRWD_T_30S;
            3'h3: delay_secs = `SBRWD_T_1M;
            3'h4: delay_secs = `SBRWD_T_2M;
            3'h5: delay_secs = `SBRWD_T_5M;
            3'h6: delay_secs = `SBRWD_T_10M;
            3'h7: delay_secs = `SBRWD_T_30M;
            default: delay_secs = 12'h000;
         endcase
      end
   endfunction

   // stage timeout selection to seconds
   function [11:0] stage_secs;
      input [3:0] sel;
      begin
         case (sel)
            4'h0: stage_secs = `SBRWD_T_1S;
            4'h1: stage_secs = `SBRWD_T_2S;
            4'h2: stage_secs = `SBRWD_T_5S;
            4'h3: stage_secs = `SBRWD_T_10S;
            4'h5: stage_secs = `SBRWD_T_1M;
            4'h6: stage_secs = `SBRWD_T_2M;
            4'h7: stage_secs = `SBRWD_T_5M;
            4'h8: stage_secs = `SBRWD_T_10M;
            default: stage_secs = `SBRWD_T_30S;
         endcase
      end
   endfunction

   // configuration and status registers
   reg [10:0] ctrl_q;
   reg [17:0] stage_cfg_q;
   reg [`SBRWD_ST_W-1:0] stat_q;
   reg [`SBRWD_ST_W-1:0] stat_d;
   reg [`SBRWD_ST_W-1:0] mask_q;
   reg [1:0] rt_state_q;
   reg [1:0] rt_state_d;
   reg [1:0] stage_q;
   reg [1:0] stage_d;
   reg post_active_q;
   reg rt_load;
   reg [11:0] rt_secs;
   reg rt_clear;
   reg [1:0] fire_ev;
   reg fire;
   reg disarm_once;
   reg [1:0] cur_ev;
   reg [3:0] cur_to;
   reg [1:0] next_stage;
   reg has_next;
   reg [31:0] rdata_d;

   wire tick;
   wire post_expired;
   wire rt_expired;
   wire [11:0] post_count;
   wire [11:0] rt_count;
   wire wr_ctrl = reg_we_i && reg_addr_i == `SBRWD_A_CTRL;
   wire wr_stage = reg_we_i && reg_addr_i == `SBRWD_A_STAGE;
   wire wr_cmd = reg_we_i && reg_addr_i == `SBRWD_A_CMD;
   wire wr_stat = reg_we_i && reg_addr_i == `SBRWD_A_STAT;
   wire wr_mask = reg_we_i && reg_addr_i == `SBRWD_A_MASK;
   wire sw_trigger = wr_cmd && reg_wdata_i[`SBRWD_CMD_TRIG];
   wire sw_arm = wr_cmd && reg_wdata_i[`SBRWD_CMD_ARM];
   wire [1:0] rt_mode = ctrl_q[`SBRWD_C_MODE];
   wire [1:0] ev1 = stage_cfg_q[`SBRWD_S_EV1];
   wire [1:0] ev2 = stage_cfg_q[`SBRWD_S_EV2];
   wire [1:0] ev3 = stage_cfg_q[`SBRWD_S_EV3];

   // boot watchdog gating
   wire post_pause = (ctrl_q[`SBRWD_C_STOP_UI] && (boot_popup_i || setup_pwd_wait_i)) || // RULE_03
                     (ctrl_q[`SBRWD_C_STOP_PW] && pwd_entry_i); // RULE_04
   wire post_start = post_active_i && !post_active_q && ctrl_q[`SBRWD_C_POST] != 3'h0; // RULE_01
   wire post_run = post_active_i && !post_pause; // RULE_02

   sbrwd_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tick_o(tick)
   );

   sbrwd_timer u_post_timer (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .load_i(post_start),
      .secs_i(post_secs(ctrl_q[`SBRWD_C_POST])), // RULE_01
      .clear_i(!post_active_i), // RULE_02
      .run_i(post_run),
      .tick_i(tick),
      .count_o(post_count),
      .expired_o(post_expired)
   );

   sbrwd_timer u_rt_timer (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .load_i(rt_load),
      .secs_i(rt_secs),
      .clear_i(rt_clear),
      .run_i(rt_state_q == ST_DELAY || rt_state_q == ST_STAGE),
      .tick_i(tick),
      .count_o(rt_count),
      .expired_o(rt_expired)
   );

   // current stage selection and successor
   always @* begin
      case (stage_q)
         2'h0: begin
            cur_ev = (ev1 == `SBRWD_EV_NONE) ? `SBRWD_EV_ACPI : ev1; // RULE_10
            cur_to = stage_cfg_q[`SBRWD_S_TO1];
         end
         2'h1: begin
            cur_ev = ev2; // RULE_11
            cur_to = stage_cfg_q[`SBRWD_S_TO2];
         end
         default: begin
            cur_ev = ev3; // RULE_12
            cur_to = stage_cfg_q[`SBRWD_S_TO3];
         end
      endcase
      has_next = 1'b0;
      next_stage = stage_q;
      if (stage_q == 2'h0 && ev2 != `SBRWD_EV_NONE) begin // RULE_16
         has_next = 1'b1;
         next_stage = 2'h1;
      end else if (stage_q != 2'h2 && ev3 != `SBRWD_EV_NONE) begin // RULE_16
         has_next = 1'b1;
         next_stage = 2'h2;
      end
   end

   // runtime watchdog sequencing
   always @* begin
      rt_state_d = rt_state_q;
      stage_d = stage_q;
      rt_load = 1'b0;
      rt_secs = stage_secs(stage_cfg_q[`SBRWD_S_TO1]);
      rt_clear = 1'b0;
      fire = 1'b0;
      fire_ev = cur_ev;
      disarm_once = 1'b0;
      case (rt_state_q)
         ST_IDLE: begin
            if (sw_arm && rt_mode != `SBRWD_M_OFF) begin // RULE_08
               stage_d = 2'h0;
               rt_load = 1'b1;
               if (ctrl_q[`SBRWD_C_DELAY] != 3'h0) begin // RULE_09
                  rt_state_d = ST_DELAY;
                  rt_secs = delay_secs(ctrl_q[`SBRWD_C_DELAY]);
               end else begin
                  rt_state_d = ST_STAGE;
               end
            end
         end
         ST_DELAY: begin
            if (rt_expired) begin // RULE_09
               rt_state_d = ST_STAGE;
               stage_d = 2'h0;
               rt_load = 1'b1;
            end
         end
         ST_STAGE: begin
            if (sw_trigger && rt_mode == `SBRWD_M_ONCE) begin // RULE_05
               rt_state_d = ST_IDLE;
               rt_clear = 1'b1;
               disarm_once = 1'b1;
            end else if (sw_trigger) begin // RULE_16
               stage_d = 2'h0;
               rt_load = 1'b1;
            end else if (rt_expired) begin
               fire = 1'b1; // RULE_10
               if (has_next) begin // RULE_16
                  stage_d = next_stage;
                  rt_load = 1'b1;
                  case (next_stage)
                     2'h1: rt_secs = stage_secs(stage_cfg_q[`SBRWD_S_TO2]); // RULE_13
                     default: rt_secs = stage_secs(stage_cfg_q[`SBRWD_S_TO3]); // RULE_13
                  endcase
               end else if (rt_mode == `SBRWD_M_REPEAT) begin // RULE_07
                  rt_load = 1'b1;
                  rt_secs = stage_secs(cur_to);
               end else begin
                  rt_state_d = ST_DONE; // RULE_06
                  rt_clear = 1'b1;
               end
            end
         end
         ST_DONE: begin
            if (sw_arm && rt_mode != `SBRWD_M_OFF) begin
               rt_state_d = ST_IDLE;
            end
         end
         default: begin
            rt_state_d = ST_IDLE;
            rt_clear = 1'b1;
         end
      endcase
      if (rt_state_q != ST_IDLE && wr_ctrl && reg_wdata_i[6:5] == `SBRWD_M_OFF) begin
         rt_state_d = ST_IDLE;
         rt_clear = 1'b1;
         rt_load = 1'b0;
         fire = 1'b0;
      end
   end

   // sticky status, set wins over write-one clear
   always @* begin
      stat_d = stat_q;
      if (wr_stat) begin
         stat_d = stat_q & ~reg_wdata_i[`SBRWD_ST_W-1:0];
      end
      if (post_expired) begin
         stat_d[`SBRWD_ST_POST] = 1'b1;
      end
      if (fire && fire_ev == `SBRWD_EV_ACPI) begin
         stat_d[`SBRWD_ST_ACPI] = 1'b1;
      end
      if (fire && fire_ev == `SBRWD_EV_RST) begin
         stat_d[`SBRWD_ST_RST] = 1'b1;
      end
      if (fire && fire_ev == `SBRWD_EV_PWR) begin
         stat_d[`SBRWD_ST_PWR] = 1'b1;
      end
      if (disarm_once) begin
         stat_d[`SBRWD_ST_OFF] = 1'b1;
      end
   end

   // read mux
   always @* begin
      case (reg_addr_i)
         `SBRWD_A_CTRL: rdata_d = {21'h000000, ctrl_q};
         `SBRWD_A_STAGE: rdata_d = {14'h0000, stage_cfg_q};
         `SBRWD_A_STAT: rdata_d = {27'h0000000, stat_q};
         `SBRWD_A_MASK: rdata_d = {27'h0000000, mask_q};
         `SBRWD_A_STATE: rdata_d = {post_count, rt_count[11:0], 2'h0, post_active_i, post_pause,
                                    stage_q, rt_state_q};
         default: rdata_d = 32'h00000000;
      endcase
   end

   assign irq_o = |(stat_q & mask_q);

   // registers and event pulses
   always @(posedge clk_sys_i) begin
      if (rst_i) begin // RULE_17
         ctrl_q <= `SBRWD_CTRL_RST;
         stage_cfg_q <= `SBRWD_STAGE_RST; // RULE_13
         stat_q <= 5'h00;
         mask_q <= 5'h00;
         rt_state_q <= ST_IDLE;
         stage_q <= 2'h0;
         post_active_q <= 1'b0;
         reg_rdata_o <= 32'h00000000;
         sys_reset_o <= 1'b0;
         pwr_button_o <= 1'b0;
         acpi_overtemp_o <= 1'b0;
         acpi_fatal_o <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata_i[10:0];
         end
         if (wr_stage) begin
            stage_cfg_q <= reg_wdata_i[17:0];
            if (reg_wdata_i[1:0] == `SBRWD_EV_NONE) begin
               stage_cfg_q[`SBRWD_S_EV1] <= `SBRWD_EV_ACPI; // RULE_10
            end
         end
         if (wr_mask) begin
            mask_q <= reg_wdata_i[`SBRWD_ST_W-1:0];
         end
         stat_q <= stat_d;
         rt_state_q <= rt_state_d;
         stage_q <= stage_d;
         post_active_q <= post_active_i;
         reg_rdata_o <= reg_re_i ? rdata_d : 32'h00000000;
         sys_reset_o <= post_expired || (fire && fire_ev == `SBRWD_EV_RST); // RULE_02
         pwr_button_o <= fire && fire_ev == `SBRWD_EV_PWR;
         acpi_overtemp_o <= fire && fire_ev == `SBRWD_EV_ACPI && !ctrl_q[`SBRWD_C_RESTART]; // RULE_14
         acpi_fatal_o <= fire && fire_ev == `SBRWD_EV_ACPI && ctrl_q[`SBRWD_C_RESTART]; // RULE_15
      end
   end
endmodule // sbrwd_top

// file: verif/sbrwd_asserts.sv
// port assertions: read slot, event pulses, interrupt cause
// assumes bind into sbrwd_top, one clock, sync high reset
`timescale 1ns/1ps
module sbrwd_asserts (
   // clock, reset
   input wire clk_sys_i,
   input wire rst_i,
   // register port
   input wire reg_we_i,
   input wire reg_re_i,
   input wire [31:0] reg_rdata_o,
   // events
   input wire sys_reset_o,
   input wire pwr_button_o,
   input wire acpi_overtemp_o,
   input wire acpi_fatal_o,
   input wire irq_o
);
   wire ev = sys_reset_o | pwr_button_o | acpi_overtemp_o | acpi_fatal_o;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   property p_rd_idle; !reg_re_i |=> reg_rdata_o == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata outside slot");
   property p_quiet; $fell(rst_i) |-> !ev && !irq_o && reg_rdata_o == 32'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("busy after reset");
   property p_rst_pulse; sys_reset_o |=> !sys_reset_o; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse long");
   property p_pwr_pulse; pwr_button_o |=> !pwr_button_o; endproperty
   a_pwr_pulse: assert property (p_pwr_pulse) else $error("power pulse long");
   property p_ot_pulse; acpi_overtemp_o |=> !acpi_overtemp_o; endproperty
   a_ot_pulse: assert property (p_ot_pulse) else $error("overtemp pulse long");
   property p_fat_pulse; acpi_fatal_o |=> !acpi_fatal_o; endproperty
   a_fat_pulse: assert property (p_fat_pulse) else $error("fatal pulse long");
   property p_acpi_one; !(acpi_overtemp_o && acpi_fatal_o); endproperty
   a_acpi_one: assert property (p_acpi_one) else $error("both acpi kinds");
   property p_irq_cause;
      $rose(irq_o) |-> ev || $past(ev) || $past(ev, 2) || $past(reg_we_i) || $past(reg_we_i, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
   c_boot: cover property (sys_reset_o);
   c_fatal: cover property (acpi_fatal_o);
   c_irq: cover property ($rose(irq_o));
endmodule // sbrwd_asserts
bind sbrwd_top sbrwd_asserts u_chk (.clk_sys_i, .rst_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
   .sys_reset_o, .pwr_button_o, .acpi_overtemp_o, .acpi_fatal_o, .irq_o);

// file: verif/sbrwd_host.sv
// host side model: counts events, turns a reset pulse into system reset
// assumes one-cycle event pulses on clk_sys_i
`timescale 1ns/1ps
module sbrwd_host (
   // clock
   input wire clk_sys_i,
   // watchdog events
   input wire sys_reset_i,
   input wire pwr_button_i,
   input wire acpi_overtemp_i,
   input wire acpi_fatal_i,
   // system reset back
   output wire rst_req_o,
   // event counts
   output logic [7:0] n_rst_o = 8'h00,
   output logic [7:0] n_pwr_o = 8'h00,
   output logic [7:0] n_ot_o = 8'h00,
   output logic [7:0] n_fat_o = 8'h00
);
   logic [1:0] hold_q = 2'h0;
   assign rst_req_o = hold_q != 2'h0;
   always @(posedge clk_sys_i) begin
      if (sys_reset_i) begin
         hold_q <= 2'h3;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
      n_rst_o <= n_rst_o + {7'h00, sys_reset_i};
      n_pwr_o <= n_pwr_o + {7'h00, pwr_button_i};
      n_ot_o <= n_ot_o + {7'h00, acpi_overtemp_i};
      n_fat_o <= n_fat_o + {7'h00, acpi_fatal_i};
   end
endmodule // sbrwd_host

// file: verif/test_staged_boot_and_runtime_watchdog.sv
// bench for the staged watchdog: boot timeouts, pauses, runtime modes, irq
// assumes host model and checker compiled with the design
`timescale 1ns/1ps
`include "sbrwd_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("wrong value t=%0t %h %h", $time, a, b); end end
module test_staged_boot_and_runtime_watchdog;
   localparam int TK = 10;
   logic clk_sys_i = 1'b0;
   logic rst_b = 1'b1;
   logic we = 1'b0;
   logic re = 1'b0;
   logic post = 1'b0;
   logic [2:0] hold = 3'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rd_q;
   logic [31:0] seed = 32'h1660;
   logic [7:0] p0;
   logic [31:0] r;
   wire [31:0] rdata;
   wire s_rst, s_pwr, s_ot, s_fat, irq, rst_h;
   wire [7:0] c_rst, c_pwr, c_ot, c_fat;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int w;
   logic [7:0] ra [6] = '{`SBRWD_A_CTRL, `SBRWD_A_STAGE, `SBRWD_A_CMD, `SBRWD_A_STAT, `SBRWD_A_MASK, 8'h20};
   logic [31:0] rv [6] = '{32'h018, 32'h11101, 32'h0, 32'h0, 32'h0, 32'h0};
   sbrwd_top #(.TICK_CYCLES(TK)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_b | rst_h), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .post_active_i(post),
      .boot_popup_i(hold[0]), .setup_pwd_wait_i(hold[1]), .pwd_entry_i(hold[2]), .sys_reset_o(s_rst),
      .pwr_button_o(s_pwr), .acpi_overtemp_o(s_ot), .acpi_fatal_o(s_fat), .irq_o(irq));
   sbrwd_host u_host (.clk_sys_i(clk_sys_i), .sys_reset_i(s_rst), .pwr_button_i(s_pwr), .acpi_overtemp_i(s_ot),
      .acpi_fatal_i(s_fat), .rst_req_o(rst_h), .n_rst_o(c_rst), .n_pwr_o(c_pwr), .n_ot_o(c_ot), .n_fat_o(c_fat));
   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int bsecs(input int c);
      int t [7] = '{0, 30, 60, 120, 300, 600, 1800};
      return t[c];
   endfunction
   function automatic bit in_win(input int n, input int s);
      return n >= s * TK - 20 && n <= s * TK + 6;
   endfunction
   function automatic logic [31:0] stg(input logic [1:0] e1, e2, e3, input logic [3:0] t1, t2, t3);
      return {14'h0, t3, t2, t1, e3, e2, e1};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk_sys_i);
      we <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_i);
      addr <= a;
      re <= 1'b1;
      @(posedge clk_sys_i);
      re <= 1'b0;
      #1 rd_q = rdata;
   endtask
   // cycles until any event count moves, capped at lim
   task automatic wait_ev(input int lim);
      int s;
      s = c_rst + c_pwr + c_ot + c_fat;
      w = 0;
      while (w < lim && c_rst + c_pwr + c_ot + c_fat == s) begin
         @(posedge clk_sys_i);
         w++;
      end
      #1;
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_b <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         `CHK(rd_q, rv[i])
      end
      post <= 1'b1;
      wait_ev(400);
      `CHK(w, 400)
      post <= 1'b0;
      for (int c = 1; c < 7; c++) begin
         wr(`SBRWD_A_CTRL, 32'h018 | c);
         post <= 1'b1;
         wait_ev(bsecs(c) * TK + 20);
         `CHK(c_rst, 8'(c))
         `CHK(in_win(w, bsecs(c)), 1'b1)
         post <= 1'b0;
         repeat (6) @(posedge clk_sys_i);
      end
      rd(`SBRWD_A_CTRL);
      `CHK(rd_q, 32'h018)
      wr(`SBRWD_A_CTRL, 32'h019);
      post <= 1'b1;
      hold <= 3'h1;
      for (int k = 0; k < 3; k++) begin
         wait_ev(400);
         `CHK(w, 400)
         rd(`SBRWD_A_STATE);
         `CHK(rd_q[5:4], 2'h3)
         `CHK(rd_q[31:20], `SBRWD_T_30S)
         hold <= hold << 1;
      end
      wait_ev(330);
      `CHK(in_win(w, 30), 1'b1)
      post <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      // both stop options off: boot timer keeps running
      wr(`SBRWD_A_CTRL, 32'h001);
      post <= 1'b1;
      hold <= 3'h7;
      wait_ev(330);
      `CHK(in_win(w, 30), 1'b1)
      post <= 1'b0;
      hold <= 3'h0;
      repeat (6) @(posedge clk_sys_i);
      // single mode, shutdown action, random trigger gaps
      wr(`SBRWD_A_MASK, 32'h1F);
      wr(`SBRWD_A_STAGE, stg(`SBRWD_EV_PWR, `SBRWD_EV_ACPI, `SBRWD_EV_ACPI, 4'h1, 4'h0, 4'h2));
      wr(`SBRWD_A_CTRL, 32'h058);
      wr(`SBRWD_A_CMD, 32'h2);
      for (int i = 0; i < 20; i++) begin
         r = rnd();
         repeat (r[1:0]) @(posedge clk_sys_i);
         wr(`SBRWD_A_CMD, {r[31:2], 2'h1});
      end
      wait_ev(40);
      `CHK(in_win(w, 2), 1'b1)
      `CHK(c_pwr, 8'h1)
      rd(`SBRWD_A_STAT);
      `CHK(rd_q[`SBRWD_ST_PWR], 1'b1)
      `CHK(irq, 1'b1)
      wait_ev(30);
      `CHK(c_ot, 8'h1)
      wait_ev(70);
      `CHK(in_win(w, 5), 1'b1)
      `CHK(c_ot, 8'h2)
      wait_ev(200);
      `CHK(w, 200)
      rd(`SBRWD_A_STATE);
      `CHK(rd_q[1:0], 2'h3)
      wr(`SBRWD_A_STAT, 32'h1F);
      `CHK(irq, 1'b0)
      // repeated mode, restart action, stage two off
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      rst_b <= 1'b0;
      wr(`SBRWD_A_STAGE, stg(`SBRWD_EV_ACPI, `SBRWD_EV_NONE, `SBRWD_EV_PWR, 4'h0, 4'h0, 4'h0));
      wr(`SBRWD_A_CTRL, 32'h478);
      p0 = c_pwr;
      wr(`SBRWD_A_CMD, 32'h2);
      wait_ev(30);
      `CHK(c_fat, 8'h1)
      `CHK(c_ot, 8'h2)
      for (int k = 0; k < 3; k++) begin
         wait_ev(30);
         `CHK(in_win(w, 1), 1'b1)
         `CHK(c_pwr, 8'(p0 + k + 1))
      end
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      rst_b <= 1'b0;
      rd(`SBRWD_A_STATE);
      `CHK(rd_q[1:0], 2'h0)
      wait_ev(100);
      `CHK(w, 100)
      // start delay then reset event
      wr(`SBRWD_A_STAGE, stg(`SBRWD_EV_RST, `SBRWD_EV_NONE, `SBRWD_EV_NONE, 4'h0, 4'h0, 4'h0));
      wr(`SBRWD_A_CTRL, 32'h0D8);
      p0 = c_rst;
      wr(`SBRWD_A_CMD, 32'h2);
      rd(`SBRWD_A_STATE);
      `CHK(rd_q[1:0], 2'h1)
      wait_ev(150);
      `CHK(in_win(w, 11), 1'b1)
      `CHK(c_rst, 8'(p0 + 1))
      repeat (6) @(posedge clk_sys_i);
      rd(`SBRWD_A_STATE);
      `CHK(rd_q[1:0], 2'h0)
      // one-time mode, masked then unmasked irq
      wr(`SBRWD_A_CTRL, 32'h038);
      wr(`SBRWD_A_CMD, 32'h2);
      wr(`SBRWD_A_CMD, 32'h1);
      rd(`SBRWD_A_STATE);
      `CHK(rd_q[1:0], 2'h0)
      rd(`SBRWD_A_STAT);
      `CHK(rd_q[`SBRWD_ST_OFF], 1'b1)
      `CHK(irq, 1'b0)
      wr(`SBRWD_A_MASK, 32'h10);
      `CHK(irq, 1'b1)
      wr(`SBRWD_A_STAT, 32'h10);
      `CHK(irq, 1'b0)
      wait_ev(400);
      `CHK(w, 400)
      finish_test();
   end
endmodule // test_staged_boot_and_runtime_watchdog
